// *** rtl/scp_clock_ctl.sv ***
// System clock prescaler control: unlock window, trim, clock out pin
`timescale 1ns/1ps
module scp_clock_ctl (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  // Fuses and factory value
  input  wire logic       divide_by_eight_fuse,
  input  wire logic       clock_out_fuse,
  input  wire logic [3:0] clock_source_fuses,
  input  wire logic [7:0] factory_trim,
  // Normal port function of the clock out pin
  input  wire logic       port_pin_out,
  input  wire logic       port_pin_oe,
  output logic            clock_out_pin,
  output logic            clock_out_pin_oe,
  // Divided clock and analog controls
  output logic            sys_clk_en,
  output logic            sys_clk_level,
  output logic      [3:0] active_prescale,
  output logic      [7:0] rc_oscillator_trim,
  output logic            rc_osc_is_sys_clk,
  output logic            timer_osc_enable,
  output logic            timer_ext_clock_enable
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [13:0]        sync_bus;
  logic               div8_sync;
  logic               clock_out_pin_sync;
  logic [3:0]         source_sync;
  logic [7:0]         trim_sync;
  logic               wr_pre;
  logic               wr_trim;
  logic               wr_timer;
  logic               unlock_wr;
  logic               sel_wr;
  logic               sel_ok;
  logic               sel_take;
  logic               tick;
  logic               div_level;
  logic               div_is_one;
  logic [3:0]         reset_sel;
  scp_pkg::scp_win_t  win_reg;
  scp_pkg::scp_win_t  win_next;
  logic [2:0]         win_cnt_reg;
  logic [3:0]         prescale_select_reg;
  logic [7:0]         trim_reg;
  logic               ext_clk_reg;
  logic               tosc_req_reg;
  logic               tosc_out_reg;
  logic               rc_sel_reg;
  logic [7:0]         rdata_reg;
  logic               prescale_change_enable;
  logic [10:0]        win_age_reg;

  // ************************************************************
  // Pin inputs
  // ************************************************************
  // Fuse levels and the factory value come from outside the clock
  scp_sync #(
    .WIDTH (scp_pkg::SYNC_WIDTH)
  ) u_sync (
    .ref_clk  (ref_clk),
    .async_in ({divide_by_eight_fuse, clock_out_fuse,
                clock_source_fuses, factory_trim}),
    .sync_out (sync_bus)
  );

  assign div8_sync   = sync_bus[13];
  assign clock_out_pin_sync   = sync_bus[12];
  assign source_sync = sync_bus[11:8];
  assign trim_sync   = sync_bus[7:0];

  // Select value loaded while reset is held
  assign reset_sel = div8_sync ? scp_pkg::SEL_RESET_DIV8
                               : scp_pkg::SEL_RESET_DIV1;

  // ************************************************************
  // Write decode
  // ************************************************************
  // Only an exact 0x80 may open the window; other bits must be zero
  assign wr_pre    = bus_wr && (bus_addr == scp_pkg::PRESCALE_OFF);
  assign wr_trim   = bus_wr && (bus_addr == scp_pkg::TRIM_OFF);
  assign wr_timer  = bus_wr && (bus_addr == scp_pkg::TIMER_CTL_OFF);
  assign unlock_wr = wr_pre && (bus_wdata == scp_pkg::UNLOCK_VALUE);
  assign sel_wr    = wr_pre && !bus_wdata[scp_pkg::CHANGE_EN_BIT];
  assign sel_ok    = (bus_wdata[3:0] <= scp_pkg::SEL_MAX);

  // A select write counts only inside the window
  assign sel_take = sel_wr && (win_reg == scp_pkg::SCP_WIN_OPEN) && sel_ok;

  // ************************************************************
  // Change enable window
  // ************************************************************
  // The window is timed in divided cycles, so a slow factor keeps it
  // open longer in master clock cycles
  always_comb begin
    win_next = win_reg;
    unique case (win_reg)
      scp_pkg::SCP_WIN_CLOSED: begin
        if (unlock_wr) begin
          win_next = scp_pkg::SCP_WIN_OPEN;
        end
      end
      scp_pkg::SCP_WIN_OPEN: begin
        if (sel_wr) begin
          win_next = scp_pkg::SCP_WIN_CLOSED;
        end else if (tick && (win_cnt_reg == scp_pkg::WINDOW_LAST)) begin
          win_next = scp_pkg::SCP_WIN_CLOSED;
        end
      end
      default: begin
        win_next = scp_pkg::SCP_WIN_CLOSED;
      end
    endcase
  end

  // Window state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      win_reg <= scp_pkg::SCP_WIN_CLOSED;
    end else begin
      win_reg <= win_next;
    end
  end

  // Divided cycle count; a repeated unlock leaves it alone
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      win_cnt_reg <= 3'h0;
    end else if (win_reg == scp_pkg::SCP_WIN_CLOSED) begin
      win_cnt_reg <= 3'h0;
    end else if (tick) begin
      win_cnt_reg <= win_cnt_reg + 3'h1;
    end
  end

  assign prescale_change_enable = (win_reg == scp_pkg::SCP_WIN_OPEN);

  // Master cycles the window has stood open, for checking only; four
  // periods at the slowest factor are the longest it may last
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !prescale_change_enable) begin
      win_age_reg <= 11'h000;
    end else begin
      win_age_reg <= win_age_reg + 11'h001;
    end
  end

  // ************************************************************
  // Prescale select
  // ************************************************************
  // Software view of the select field; a reserved code is dropped
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prescale_select_reg <= reset_sel;
    end else if (sel_take) begin
      prescale_select_reg <= bus_wdata[3:0];
    end
  end

  // Divider; the new factor lands only at an old period boundary
  scp_divider u_div (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .reset_sel     (reset_sel),
    .new_sel       (bus_wdata[3:0]),
    .new_sel_valid (sel_take),
    .active_sel    (active_prescale),
    .sys_clk_tick  (tick),
    .div_level     (div_level),
    .div_is_one    (div_is_one)
  );

  // One enable paces all synchronous domains alike
  assign sys_clk_en    = tick;
  assign sys_clk_level = div_level;

  // ************************************************************
  // Oscillator trim
  // ************************************************************
  // Factory value is caught on every reset cycle, then software owns it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trim_reg <= trim_sync;
    end else if (wr_trim) begin
      trim_reg <= bus_wdata;
    end
  end

  // Bit 7 is the range select, bits 6:0 the fine step
  assign rc_oscillator_trim = trim_reg;

  // ************************************************************
  // Timer oscillator control
  // ************************************************************
  // Control bits of the asynchronous timer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_clk_reg  <= 1'b0;
      tosc_req_reg <= 1'b0;
    end else if (wr_timer) begin
      ext_clk_reg  <= bus_wdata[scp_pkg::EXT_CLK_BIT];
      tosc_req_reg <= bus_wdata[scp_pkg::TOSC_EN_BIT];
    end
  end

  // The crystal pins are shared, so the timer oscillator is refused
  // unless the RC oscillator clocks the chip
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rc_sel_reg   <= 1'b0;
      tosc_out_reg <= 1'b0;
    end else begin
      rc_sel_reg   <= (source_sync == scp_pkg::RC_OSC_SOURCE);
      tosc_out_reg <= tosc_req_reg && rc_sel_reg;
    end
  end

  assign rc_osc_is_sys_clk      = rc_sel_reg;
  assign timer_osc_enable       = tosc_out_reg;
  assign timer_ext_clock_enable = ext_clk_reg;

  // ************************************************************
  // Clock out pin
  // ************************************************************
  // At factor one the master clock itself is the divided clock; the mux
  // only flips at a period boundary, where both inputs are high
  always_comb begin
    if (clock_out_pin_sync) begin
      clock_out_pin    = div_is_one ? ref_clk : div_level;
      clock_out_pin_oe = 1'b1;
    end else begin
      clock_out_pin    = port_pin_out;
      clock_out_pin_oe = port_pin_oe;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  // Data stand for one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      unique case (bus_addr)
        scp_pkg::PRESCALE_OFF: begin
          rdata_reg <= {prescale_change_enable, 3'h0, prescale_select_reg};
        end
        scp_pkg::TRIM_OFF: begin
          rdata_reg <= trim_reg;
        end
        scp_pkg::TIMER_CTL_OFF: begin
          rdata_reg <= {1'b0, ext_clk_reg, tosc_req_reg, 5'h00};
        end
        default: begin
          rdata_reg <= 8'h00;
        end
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign bus_rdata = rdata_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  a_unlock_exact: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    wr_pre && !prescale_change_enable && bus_wdata != scp_pkg::UNLOCK_VALUE
    |=> !prescale_change_enable)
    else $error("Change enable set by an impure write");

  a_window_closes: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    prescale_change_enable |-> win_age_reg < 11'h400)
    else $error("Change enable window did not close");

  a_select_closes: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    sel_wr && prescale_change_enable |=> !prescale_change_enable)
    else $error("Select write left the window open");

  a_no_restart: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    unlock_wr && prescale_change_enable && !tick
    |=> prescale_change_enable && win_cnt_reg == $past(win_cnt_reg))
    else $error("Repeated unlock changed the window");

  a_select_reset: assert property (
    @(posedge ref_clk)
    sys_rst && $past(sys_rst) && $past(sys_rst, 2)
    |=> prescale_select_reg == ($past(div8_sync) ? 4'h3 : 4'h0))
    else $error("Select reset value wrong for fuse");

  a_select_locked: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $changed(prescale_select_reg) && !$past(sys_rst)
    |-> $past(prescale_change_enable) && $past(bus_wdata[3:0]) <= 4'h8)
    else $error("Select changed without a valid unlocked write");

  a_trim_reset: assert property (
    @(posedge ref_clk)
    sys_rst && $past(sys_rst) && $past(sys_rst, 2)
    |=> trim_reg == $past(trim_sync))
    else $error("Trim not loaded with factory value");

  a_tosc_gate: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    timer_osc_enable |-> $past(rc_sel_reg))
    else $error("Timer oscillator on without RC clock source");

  a_clock_out_pin_drive: assert property (
    @(posedge ref_clk)
    clock_out_pin_sync |-> clock_out_pin_oe)
    else $error("Clock out pin not driven with fuse set");

endmodule

// *** rtl/scp_divider.sv ***
// Glitch free power of two divider running on the undivided master clock
`timescale 1ns/1ps
module scp_divider (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reset_sel,
  input  wire logic [3:0] new_sel,
  input  wire logic       new_sel_valid,
  output logic      [3:0] active_sel,
  output logic            sys_clk_tick,
  output logic            div_level,
  output logic            div_is_one
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic [3:0] pend_sel_reg;
  logic       pend_reg;
  logic       edge_reg;
  logic       edge_next;
  logic       level_reg;
  logic       level_next;
  logic [7:0] gap_reg;

  // ************************************************************
  // Counter and switch point
  // ************************************************************
  // A new factor is only taken at the end of an old period, so
  // no shortened pulse can appear on the divided clocks
  always_comb begin
    sel_next = sel_reg;
    cnt_next = cnt_reg + 8'h01;
    if (edge_reg) begin
      cnt_next = 8'h00;
      if (pend_reg) begin
        sel_next = pend_sel_reg;
      end
    end
    edge_next  = (cnt_next == scp_pkg::scp_div_mask(sel_next));
    level_next = scp_pkg::scp_div_high(cnt_next, sel_next);
  end

  // Synchronous count state, never visible to software
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg   <= 8'h00;
      sel_reg   <= reset_sel;
      edge_reg  <= (scp_pkg::scp_div_mask(reset_sel) == 8'h00);
      level_reg <= 1'b1;
    end else begin
      cnt_reg   <= cnt_next;
      sel_reg   <= sel_next;
      edge_reg  <= edge_next;
      level_reg <= level_next;
    end
  end

  // Pending request; a later request before the switch replaces it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_reg     <= 1'b0;
      pend_sel_reg <= 4'h0;
    end else begin
      if (new_sel_valid) begin
        pend_reg     <= 1'b1;
        pend_sel_reg <= new_sel;
      end else if (edge_reg) begin
        pend_reg     <= 1'b0;
      end
    end
  end

  assign active_sel   = sel_reg;
  assign sys_clk_tick = edge_reg;
  assign div_level    = level_reg;
  assign div_is_one   = (sel_reg == 4'h0);

  // Cycles since the last divided edge, for checking only
  always_ff @(posedge ref_clk) begin
    if (sys_rst || edge_reg) begin
      gap_reg <= 8'h00;
    end else begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  a_period_length: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    edge_reg && !$past(sys_rst) |-> gap_reg == scp_pkg::scp_div_mask(sel_reg))
    else $error("Divided period does not match factor");

  a_level_rise: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(level_reg) |-> $past(edge_reg))
    else $error("Divided clock rose away from a period edge");

  a_switch_edge: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    pend_reg && edge_reg |=> sel_reg == $past(pend_sel_reg) && cnt_reg == 8'h00)
    else $error("Factor not taken at end of old period");

endmodule

// *** rtl/scp_pkg.sv ***
// Shared constants, types and decode functions of the system clock prescaler
package scp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] PRESCALE_OFF  = 8'h61;
  localparam logic [7:0] TRIM_OFF      = 8'h66;
  localparam logic [7:0] TIMER_CTL_OFF = 8'h62;
  localparam logic [7:0] UNLOCK_VALUE  = 8'h80;
  localparam int         CHANGE_EN_BIT = 7;
  localparam int         EXT_CLK_BIT   = 6;
  localparam int         TOSC_EN_BIT   = 5;

  // ************************************************************
  // Reset values, codes and counts
  // ************************************************************
  localparam logic [3:0] SEL_RESET_DIV1 = 4'h0;
  localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
  localparam logic [3:0] SEL_MAX        = 4'h8;
  localparam logic [3:0] RC_OSC_SOURCE  = 4'h2;
  localparam logic [2:0] WINDOW_LAST    = 3'h3;
  localparam int         SYNC_WIDTH     = 14;

  // Change enable window state
  typedef enum logic [1:0] {
    SCP_WIN_CLOSED = 2'b01,
    SCP_WIN_OPEN   = 2'b10
  } scp_win_t;

  // Last count value of a divided period for a select code
  function automatic logic [7:0] scp_div_mask(input logic [3:0] sel);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // High phase of the divided clock is the first half of the period
  function automatic logic scp_div_high(input logic [7:0] cnt, input logic [3:0] sel);
    logic [7:0] m;
    m = scp_div_mask(sel);
    return ~|(cnt & m & ~(m >> 1));
  endfunction

endpackage

// *** rtl/scp_sync.sv ***
// Two flip-flop synchroniser for static straps and factory values
`timescale 1ns/1ps
module scp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // No reset here so that fuse levels act even while reset is held
  always_ff @(posedge ref_clk) begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
  end

endmodule

// *** testbench/scp_clock_ctl_tb.sv ***
// Self-checking bench for the system clock prescaler control block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module scp_clock_ctl_tb;
  logic       ref_clk;
  logic       sys_rst;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic       div8_fuse;
  logic       out_fuse;
  logic [3:0] src_fuses;
  logic [7:0] fact_trim;
  logic       port_pin_out;
  logic       port_pin_oe;
  logic       clock_out_pin;
  logic       clock_out_pin_oe;
  logic       sys_clk_en;
  logic       sys_clk_level;
  logic [3:0] active_prescale;
  logic [7:0] rc_oscillator_trim;
  logic       rc_osc_is_sys_clk;
  logic       timer_osc_enable;
  logic       timer_ext_clock_enable;
  int         n_fail;
  int         samples_checked;
  int         cycles;
  int         n;
  int         c;
  int         old_f;

  scp_clock_ctl i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .divide_by_eight_fuse(div8_fuse), .clock_out_fuse(out_fuse),
    .clock_source_fuses(src_fuses), .factory_trim(fact_trim),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .clock_out_pin(clock_out_pin), .clock_out_pin_oe(clock_out_pin_oe),
    .sys_clk_en(sys_clk_en), .sys_clk_level(sys_clk_level),
    .active_prescale(active_prescale), .rc_oscillator_trim(rc_oscillator_trim),
    .rc_osc_is_sys_clk(rc_osc_is_sys_clk), .timer_osc_enable(timer_osc_enable),
    .timer_ext_clock_enable(timer_ext_clock_enable)
  );

  // ************************************************************
  // Clock, watchdog and bus tasks
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the longest test needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    #1;
    `CHK(bus_rdata, exp)
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask

  // Cycles between two divided clock enable pulses
  task automatic period(output int p);
    int k;
    k = 0;
    @(posedge ref_clk);
    #1;
    while (sys_clk_en !== 1'b1 && k < 600) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    p = 0;
    do begin
      @(posedge ref_clk);
      #1;
      p++;
    end while (sys_clk_en !== 1'b1 && p < 600);
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    sys_rst = 1'b1; bus_addr = 8'h00; bus_wdata = 8'h00; bus_wr = 1'b0; bus_rd = 1'b0;
    div8_fuse = 1'b1; out_fuse = 1'b0; src_fuses = 4'h2; fact_trim = 8'h5A;
    port_pin_out = 1'b1; port_pin_oe = 1'b0;
    n_fail = 0; samples_checked = 0; cycles = 0;
    do_reset();
    // Reset loads divide by eight and the factory trim
    rd(scp_pkg::PRESCALE_OFF, 8'h03);
    rd(scp_pkg::TRIM_OFF, 8'h5A);
    `CHK(active_prescale, 4'h3)
    rd(8'h70, 8'h00);
    wr(scp_pkg::TRIM_OFF, 8'h7F);
    rd(scp_pkg::TRIM_OFF, 8'h7F);
    wr(scp_pkg::TRIM_OFF, 8'h80);
    rd(scp_pkg::TRIM_OFF, 8'h80);
    `CHK(rc_oscillator_trim, 8'h80)
    wr(8'h70, 8'hFF);
    rd(scp_pkg::TRIM_OFF, 8'h80);
    // Change enable only sets when the other bits are zero
    wr(scp_pkg::PRESCALE_OFF, 8'h81);
    rd(scp_pkg::PRESCALE_OFF, 8'h03);
    wr(scp_pkg::PRESCALE_OFF, 8'h01);
    rd(scp_pkg::PRESCALE_OFF, 8'h03);
    $display("test reset_regs done");
    // Every legal code, switch delay and resulting period
    old_f = 8;
    for (int s = 0; s <= 8; s++) begin
      wr(scp_pkg::PRESCALE_OFF, 8'h80);
      wr(scp_pkg::PRESCALE_OFF, 8'(s));
      c = 0;
      while (active_prescale !== 4'(s) && c < 1000) begin
        @(posedge ref_clk);
        c++;
      end
      `CHK(c <= old_f + 2 * (1 << s) + 2, 1'b1)
      rd(scp_pkg::PRESCALE_OFF, 8'(s));
      period(n);
      `CHK(n, 1 << s)
      old_f = 1 << s;
    end
    $display("test prescale_codes done");
    // Reserved code keeps the division and closes the window
    wr(scp_pkg::PRESCALE_OFF, 8'h80);
    wr(scp_pkg::PRESCALE_OFF, 8'h09);
    rd(scp_pkg::PRESCALE_OFF, 8'h08);
    `CHK(active_prescale, 4'h8)
    $display("test reserved_code done");
    // At factor 1 the window lasts four cycles and is not restarted
    wr(scp_pkg::PRESCALE_OFF, 8'h80);
    wr(scp_pkg::PRESCALE_OFF, 8'h80);
    wr(scp_pkg::PRESCALE_OFF, 8'h00);
    period(n);
    `CHK(n, 1)
    wr(scp_pkg::PRESCALE_OFF, 8'h80);
    rd(scp_pkg::PRESCALE_OFF, 8'h80);
    wr(scp_pkg::PRESCALE_OFF, 8'h80);
    wr(scp_pkg::PRESCALE_OFF, 8'h02);
    rd(scp_pkg::PRESCALE_OFF, 8'h00);
    $display("test change_window done");
    // Timer oscillator only with the RC source; external clock bit
    wr(scp_pkg::TIMER_CTL_OFF, 8'h60);
    repeat (2) @(posedge ref_clk);
    `CHK(timer_osc_enable, 1'b1)
    `CHK(timer_ext_clock_enable, 1'b1)
    `CHK(rc_osc_is_sys_clk, 1'b1)
    src_fuses <= 4'h0;
    repeat (5) @(posedge ref_clk);
    `CHK(timer_osc_enable, 1'b0)
    `CHK(rc_osc_is_sys_clk, 1'b0)
    rd(scp_pkg::TIMER_CTL_OFF, 8'h60);
    wr(scp_pkg::TIMER_CTL_OFF, 8'h00);
    repeat (2) @(posedge ref_clk);
    `CHK(timer_ext_clock_enable, 1'b0)
    $display("test timer_osc done");
    // Clock out pin: port function, then divided clock, also in reset
    #1;
    `CHK(clock_out_pin, 1'b1)
    `CHK(clock_out_pin_oe, 1'b0)
    wr(scp_pkg::PRESCALE_OFF, 8'h80);
    wr(scp_pkg::PRESCALE_OFF, 8'h01);
    out_fuse <= 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      #1;
      `CHK(clock_out_pin, ~sys_clk_en)
      `CHK(sys_clk_level, ~sys_clk_en)
    end
    @(posedge ref_clk);
    div8_fuse <= 1'b0;
    sys_rst   <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(clock_out_pin_oe, 1'b1)
    do_reset();
    rd(scp_pkg::PRESCALE_OFF, 8'h00);
    $display("test clock_out done");
    stop_test();
  end
endmodule
